/* src/aerusm_top.sv */
// aerusm top: uncorrectable error status and mask registers over apb
//
// Register access over APB was decided locally.
`timescale 1ns/1ns
module aerusm_top
  import aerusm_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic        i_por_rst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [3:0]  i_pstrb,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire aerusm_evt_t i_err_evt,
  input  wire logic        i_surprise_down_report_capable,
  input  wire logic        i_next_capability_pointer_lock,
  output logic      [31:0] o_err_report,
  output logic      [31:0] o_err_log,
  output logic             o_irq
);

  // ***********************************
  // state
  // ***********************************
  logic [31:0] stat_q;
  logic [31:0] stat_d;
  logic [31:0] mask_q;
  logic [31:0] mask_d;
  logic [11:0] nxt_q;
  logic [11:0] nxt_d;
  logic [1:0]  ist_q;
  logic [1:0]  ist_d;
  logic [1:0]  imask_q;
  logic [1:0]  imask_d;
  logic [31:0] rdata_q;
  logic        slverr_q;
  logic [31:0] rpt_q;
  logic [31:0] log_q;

  // ***********************************
  // bus decode
  // ***********************************
  wire         setup    = i_psel & ~i_penable;
  wire         access   = i_psel & i_penable;
  wire         wr       = access & i_pwrite;
  wire         hit_cap  = (i_paddr == AERUSM_OFF_CAP);
  wire         hit_stat = (i_paddr == AERUSM_OFF_STAT);
  wire         hit_mask = (i_paddr == AERUSM_OFF_MASK);
  wire         hit_ist  = (i_paddr == AERUSM_OFF_ISTAT);
  wire         hit_imsk = (i_paddr == AERUSM_OFF_IMASK);
  wire         mapped   = hit_cap | hit_stat | hit_mask | hit_ist | hit_imsk;
  wire [31:0]  lanes    = {{8{i_pstrb[3]}}, {8{i_pstrb[2]}},
                           {8{i_pstrb[1]}}, {8{i_pstrb[0]}}};
  wire [31:0]  wbits    = i_pwdata & lanes;

  // ***********************************
  // error events into status positions
  // ***********************************
  wire         sd_cap   = i_surprise_down_report_capable;
  logic [31:0] evt_vec;
  always_comb
  begin
    evt_vec                    = '0;
    evt_vec[AERUSM_B_LINK]     = i_err_evt.link_protocol_error;
    evt_vec[AERUSM_B_SDOWN]    = i_err_evt.surprise_link_down_error & sd_cap;
    evt_vec[AERUSM_B_POISON]   = i_err_evt.poisoned;
    evt_vec[AERUSM_B_FCTL]     = i_err_evt.flow_control_error;
    evt_vec[AERUSM_B_UCPL]     = i_err_evt.unexpected_completion;
    evt_vec[AERUSM_B_RXOVF]    = i_err_evt.receive_overflow;
    evt_vec[AERUSM_B_MALF]     = i_err_evt.malformed;
    evt_vec[AERUSM_B_ECRC]     = i_err_evt.ecrc;
    evt_vec[AERUSM_B_UNSUP]    = i_err_evt.unsupported;
  end

  // unmasked events are logged and reported, masked ones suppressed
  wire [31:0]  rpt_vec  = evt_vec & ~mask_q;
  wire [31:0]  supp_vec = evt_vec & mask_q;

  // ***********************************
  // next values
  // ***********************************
  // status: set wins over a write-one clear
  wire [31:0]  stat_clr = (wr && hit_stat) ? wbits : '0;
  assign stat_d = ((stat_q & ~stat_clr) | evt_vec) & AERUSM_ERR_BITS;
  assign mask_d = (wr && hit_mask)
                ? ((mask_q & ~lanes) | wbits) & AERUSM_ERR_BITS
                : mask_q;
  // next pointer writable only while unlocked
  wire         nxt_we   = wr & hit_cap & ~i_next_capability_pointer_lock;
  wire [11:0]  nxt_ln   = lanes[31:20];
  assign nxt_d  = nxt_we
                ? (nxt_q & ~nxt_ln) | (i_pwdata[31:20] & nxt_ln)
                : nxt_q;
  wire [1:0]   int_evt  = {|supp_vec, |rpt_vec};
  wire [1:0]   ist_clr  = (wr && hit_ist) ? wbits[1:0] : 2'h0;
  assign ist_d  = ((ist_q & ~ist_clr) | int_evt) & AERUSM_INT_BITS;
  assign imask_d = (wr && hit_imsk)
                 ? ((imask_q & ~lanes[1:0]) | wbits[1:0]) & AERUSM_INT_BITS
                 : imask_q;

  // ***********************************
  // read views
  // ***********************************
  logic [31:0] stat_rd;
  always_comb
  begin
    stat_rd                  = stat_q;
    stat_rd[AERUSM_B_SDOWN]  = stat_q[AERUSM_B_SDOWN] & sd_cap;
    stat_rd[AERUSM_B_CPLTO]  = 1'b0;
    stat_rd[AERUSM_B_COMPLETER_ABORT] = 1'b0;
  end
  wire [31:0]  cap_rd   = {nxt_q, AERUSM_CAP_VER, AERUSM_CAP_ID};
  wire [31:0]  rd_mux   = hit_cap  ? cap_rd
                        : hit_stat ? stat_rd
                        : hit_mask ? mask_q
                        : hit_ist  ? {30'h0, ist_q}
                        : hit_imsk ? {30'h0, imask_q}
                        : 32'h0;

  // ***********************************
  // sticky registers: power-on reset only
  // ***********************************
  always_ff @(posedge i_ref_clk)
  begin
    if (i_por_rst)
    begin
      stat_q <= AERUSM_ERR_RST;
      mask_q <= AERUSM_ERR_RST;
    end
    else
    begin
      stat_q <= stat_d;
      mask_q <= mask_d;
    end
  end

  // ***********************************
  // ordinary registers
  // ***********************************
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst || i_por_rst)
    begin
      nxt_q    <= AERUSM_NEXT_CAPABILITY_POINTER_RST;
      ist_q    <= AERUSM_INT_RST;
      imask_q  <= AERUSM_INT_RST;
      rdata_q  <= '0;
      slverr_q <= 1'b0;
      rpt_q    <= '0;
      log_q    <= '0;
    end
    else
    begin
      nxt_q    <= nxt_d;
      ist_q    <= ist_d;
      imask_q  <= imask_d;
      rpt_q    <= rpt_vec;
      log_q    <= rpt_vec;
      if (setup)
      begin
        rdata_q  <= i_pwrite ? 32'h0 : rd_mux;
        slverr_q <= ~mapped;
      end
    end
  end

  // ***********************************
  // outputs
  // ***********************************
  assign o_prdata     = rdata_q;
  assign o_pready     = access;
  assign o_pslverr    = access & slverr_q;
  assign o_err_report = rpt_q;
  assign o_err_log    = log_q;
  assign o_irq        = |(ist_q & imask_q);

  // ***********************************
  // assertions
  // ***********************************
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst || i_por_rst);

  AST_CAP_HDR: assert property (
    setup && !i_pwrite && hit_cap |=> o_prdata[15:0] == AERUSM_CAP_ID
      && o_prdata[31:20] == nxt_q)
    else $error("capability header read wrong");
  AST_CAP_VER: assert property (
    setup && !i_pwrite && hit_cap |=> o_prdata[19:16] == AERUSM_CAP_VER)
    else $error("capability version wrong");
  AST_LINK_SET: assert property (
    i_err_evt.link_protocol_error |=> stat_q[AERUSM_B_LINK] [*2])
    else $error("link protocol status not held");
  AST_SDOWN_ZERO: assert property (
    !sd_cap |-> !stat_rd[AERUSM_B_SDOWN])
    else $error("surprise down read one without capability");
  AST_POISON: assert property (
    i_err_evt.poisoned |=> stat_q[AERUSM_B_POISON])
    else $error("poisoned status not set");
  AST_FCTL: assert property (
    i_err_evt.flow_control_error |=> stat_q[AERUSM_B_FCTL])
    else $error("flow control status not set");
  AST_CPLTO: assert property (
    setup && !i_pwrite && (hit_stat || hit_mask) |=> !o_prdata[AERUSM_B_CPLTO])
    else $error("completion timeout bit read one");
  AST_COMPLETER_ABORT: assert property (
    wr && hit_mask |=> !mask_q[AERUSM_B_COMPLETER_ABORT] && !stat_q[AERUSM_B_COMPLETER_ABORT])
    else $error("completer abort bit not zero");
  AST_UCPL: assert property (
    i_err_evt.unexpected_completion |=> stat_q[AERUSM_B_UCPL])
    else $error("unexpected completion status not set");
  AST_RXOVF: assert property (
    i_err_evt.receive_overflow |=> stat_q[AERUSM_B_RXOVF])
    else $error("receive overflow status not set");
  AST_MALF: assert property (
    i_err_evt.malformed |=> stat_q[AERUSM_B_MALF])
    else $error("malformed status not set");
  AST_ECRC: assert property (
    i_err_evt.ecrc |=> stat_q[AERUSM_B_ECRC])
    else $error("crc status not set");
  AST_UNSUP: assert property (
    i_err_evt.unsupported |=> stat_q[AERUSM_B_UNSUP])
    else $error("unsupported request status not set");
  AST_MASKED: assert property (
    i_err_evt.poisoned && mask_q[AERUSM_B_POISON]
      |=> !o_err_report[AERUSM_B_POISON] && ist_q[AERUSM_INT_SUPP])
    else $error("masked error reported");
  AST_RSVD: assert property (
    wr && (hit_stat || hit_mask) |=> ((stat_q | mask_q) & ~AERUSM_ERR_BITS) == 32'h0)
    else $error("reserved bit took a write");
  AST_STICKY: assert property (
    disable iff (i_por_rst)
    stat_q[AERUSM_B_POISON] && !(wr && hit_stat) ##1 i_rst && !i_por_rst && !(wr && hit_stat)
      |=> stat_q[AERUSM_B_POISON])
    else $error("sticky bit lost on ordinary reset");

  // ***********************************
  // further checks per bit and register
  // ***********************************
  AST_LINK_STAT: assert property (
    i_err_evt.link_protocol_error |=> stat_q[AERUSM_B_LINK])
    else $error("link protocol status not set");

  AST_SDOWN_SET: assert property (
    i_err_evt.surprise_link_down_error && sd_cap |=> stat_q[AERUSM_B_SDOWN])
    else $error("surprise down status not set");

  AST_SDOWN_BLOCK: assert property (
    i_err_evt.surprise_link_down_error && !sd_cap && !stat_q[AERUSM_B_SDOWN]
      |=> !stat_q[AERUSM_B_SDOWN])
    else $error("surprise down set without capability");

  AST_SDOWN_RD: assert property (
    setup && !i_pwrite && hit_stat && !sd_cap |=> !o_prdata[AERUSM_B_SDOWN])
    else $error("surprise down read one without capability");

  AST_STAT_ABORT_RD: assert property (
    setup && !i_pwrite && hit_stat |=> !o_prdata[AERUSM_B_COMPLETER_ABORT])
    else $error("completer abort status read one");

  AST_MASK_ABORT_RD: assert property (
    setup && !i_pwrite && hit_mask |=> !o_prdata[AERUSM_B_COMPLETER_ABORT])
    else $error("completer abort mask read one");

  AST_MASK_CPLTO: assert property (
    wr && hit_mask |=> !mask_q[AERUSM_B_CPLTO] && !stat_q[AERUSM_B_CPLTO])
    else $error("completion timeout bit not zero");

  AST_W1C_CLEAR: assert property (
    wr && hit_stat && i_pwdata[AERUSM_B_POISON] && i_pstrb[1] && !i_err_evt.poisoned
      |=> !stat_q[AERUSM_B_POISON])
    else $error("poisoned status not cleared by write one");

  AST_SET_WINS: assert property (
    wr && hit_stat && i_err_evt.poisoned |=> stat_q[AERUSM_B_POISON])
    else $error("poisoned event lost to a clear");

  AST_FCTL_HOLD: assert property (
    stat_q[AERUSM_B_FCTL] && !(wr && hit_stat) |=> stat_q[AERUSM_B_FCTL])
    else $error("flow control status not sticky");

  AST_UCPL_HOLD: assert property (
    stat_q[AERUSM_B_UCPL] && !(wr && hit_stat) |=> stat_q[AERUSM_B_UCPL])
    else $error("unexpected completion status not sticky");

  AST_RXOVF_HOLD: assert property (
    stat_q[AERUSM_B_RXOVF] && !(wr && hit_stat) |=> stat_q[AERUSM_B_RXOVF])
    else $error("receive overflow status not sticky");

  AST_MALF_HOLD: assert property (
    stat_q[AERUSM_B_MALF] && !(wr && hit_stat) |=> stat_q[AERUSM_B_MALF])
    else $error("malformed status not sticky");

  AST_ECRC_HOLD: assert property (
    stat_q[AERUSM_B_ECRC] && !(wr && hit_stat) |=> stat_q[AERUSM_B_ECRC])
    else $error("crc status not sticky");

  AST_UNSUP_HOLD: assert property (
    stat_q[AERUSM_B_UNSUP] && !(wr && hit_stat) |=> stat_q[AERUSM_B_UNSUP])
    else $error("unsupported request status not sticky");

  AST_RPT_UNMASKED: assert property (
    i_err_evt.poisoned && !mask_q[AERUSM_B_POISON]
      |=> o_err_report[AERUSM_B_POISON] && o_err_log[AERUSM_B_POISON])
    else $error("unmasked error not reported");

  AST_LOG_MASKED: assert property (
    i_err_evt.malformed && mask_q[AERUSM_B_MALF] |=> !o_err_log[AERUSM_B_MALF])
    else $error("masked error logged");

  AST_LINK_MASKED: assert property (
    i_err_evt.link_protocol_error && mask_q[AERUSM_B_LINK] |=> !o_err_report[AERUSM_B_LINK])
    else $error("masked link error reported");

  AST_MASK_WRITE: assert property (
    wr && hit_mask && i_pstrb[1] && i_pwdata[AERUSM_B_POISON] |=> mask_q[AERUSM_B_POISON])
    else $error("mask bit did not take a write");

  AST_MASK_HOLD: assert property (
    !(wr && hit_mask) |=> mask_q == $past(mask_q))
    else $error("mask changed without a write");

  AST_NO_EVT_RPT: assert property (
    !(|evt_vec) |=> o_err_report == 32'h0)
    else $error("report without an event");

  AST_LOG_EQ: assert property (
    o_err_log == o_err_report)
    else $error("log strobe differs from report");

  AST_RSVD_STAT: assert property (
    (stat_q & ~AERUSM_ERR_BITS) == 32'h0)
    else $error("reserved status bit set");

  AST_RSVD_RD: assert property (
    setup && !i_pwrite && (hit_stat || hit_mask) |=> (o_prdata & ~AERUSM_ERR_BITS) == 32'h0)
    else $error("reserved bit read one");

  AST_OBSOLETE: assert property (
    !stat_q[AERUSM_B_OBSOLETE] |=> !stat_q[AERUSM_B_OBSOLETE])
    else $error("obsolete status bit set by hardware");

  AST_STICKY_MASK: assert property (
    disable iff (i_por_rst)
    mask_q[AERUSM_B_LINK] && !(wr && hit_mask) ##1 i_rst && !i_por_rst && !(wr && hit_mask)
      |=> mask_q[AERUSM_B_LINK])
    else $error("sticky mask lost on ordinary reset");

  AST_POR_CLEAR: assert property (
    disable iff (1'b0)
    i_por_rst |=> stat_q == AERUSM_ERR_RST && mask_q == AERUSM_ERR_RST)
    else $error("power-on reset did not clear sticky bits");

  AST_NXT_LOCK: assert property (
    wr && hit_cap && i_next_capability_pointer_lock |=> nxt_q == $past(nxt_q))
    else $error("locked next pointer changed");

  AST_CAP_RO: assert property (
    setup && !i_pwrite && hit_cap |=> o_prdata[19:0] == {AERUSM_CAP_VER, AERUSM_CAP_ID})
    else $error("capability id or version changed");

endmodule

/* src/aerusm_pkg.sv */
// aerusm package: map, field positions, reset values and carrier types
package aerusm_pkg;

  // ***********************************
  // register offsets
  // ***********************************
  localparam logic [11:0] AERUSM_OFF_CAP   = 12'h100;
  localparam logic [11:0] AERUSM_OFF_STAT  = 12'h104;
  localparam logic [11:0] AERUSM_OFF_MASK  = 12'h108;
  localparam logic [11:0] AERUSM_OFF_ISTAT = 12'h110;
  localparam logic [11:0] AERUSM_OFF_IMASK = 12'h114;

  // ***********************************
  // capability header fields
  // ***********************************
  localparam logic [15:0] AERUSM_CAP_ID      = 16'h0001;
  localparam logic [3:0]  AERUSM_CAP_VER     = 4'h1;
  localparam logic [11:0] AERUSM_NEXT_CAPABILITY_POINTER_RST  = 12'h180;
  localparam int          AERUSM_NEXT_CAPABILITY_POINTER_LSB  = 20;

  // ***********************************
  // error bit positions
  // ***********************************
  localparam int AERUSM_B_OBSOLETE = 0;
  localparam int AERUSM_B_LINK     = 4;
  localparam int AERUSM_B_SDOWN    = 5;
  localparam int AERUSM_B_POISON   = 12;
  localparam int AERUSM_B_FCTL     = 13;
  localparam int AERUSM_B_CPLTO    = 14;
  localparam int AERUSM_B_COMPLETER_ABORT   = 15;
  localparam int AERUSM_B_UCPL     = 16;
  localparam int AERUSM_B_RXOVF    = 17;
  localparam int AERUSM_B_MALF     = 18;
  localparam int AERUSM_B_ECRC     = 19;
  localparam int AERUSM_B_UNSUP    = 20;

  // ***********************************
  // implemented bits and reset values
  // ***********************************
  localparam logic [31:0] AERUSM_ERR_BITS  = 32'h001f_3031;
  localparam logic [31:0] AERUSM_ERR_RST   = 32'h0000_0000;
  localparam logic [1:0]  AERUSM_INT_BITS  = 2'h3;
  localparam logic [1:0]  AERUSM_INT_RST   = 2'h0;
  localparam int          AERUSM_INT_RPT   = 0;
  localparam int          AERUSM_INT_SUPP  = 1;

  // error events from link and transaction logic
  typedef struct packed {
    logic link_protocol_error;
    logic surprise_link_down_error;
    logic poisoned;
    logic flow_control_error;
    logic unexpected_completion;
    logic receive_overflow;
    logic malformed;
    logic ecrc;
    logic unsupported;
  } aerusm_evt_t;

endpackage

/* tb/aer_uncorrectable_status_mask_test.sv */
// testbench for the uncorrectable error status and mask registers
`timescale 1ns/1ns
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin n_errors++; $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module aer_uncorrectable_status_mask_test;
  import aerusm_pkg::*;
  // ***********************************
  // stimulus and observed signals
  // ***********************************
  logic        i_ref_clk, i_rst, i_por_rst, i_psel, i_penable, i_pwrite;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, o_err_report, o_err_log, r, l;
  logic [3:0]  i_pstrb;
  logic        o_pready, o_pslverr, o_irq, i_surprise_down_report_capable, i_next_capability_pointer_lock, e;
  aerusm_evt_t i_err_evt;
  int          n_errors = 0;
  int          checks = 0;
  aerusm_top uut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_por_rst(i_por_rst), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .i_pstrb(i_pstrb), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_err_evt(i_err_evt), .i_surprise_down_report_capable(i_surprise_down_report_capable),
    .i_next_capability_pointer_lock(i_next_capability_pointer_lock), .o_err_report(o_err_report), .o_err_log(o_err_log),
    .o_irq(o_irq));
  initial i_ref_clk = 1'b0;
  always #10 i_ref_clk = ~i_ref_clk;
  // ***********************************
  // bus and event tasks
  // ***********************************
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] q, output logic er);
    int n;
    n = 0;
    @(posedge i_ref_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    i_pstrb <= s;
    @(posedge i_ref_clk);
    i_penable <= 1'b1;
    @(posedge i_ref_clk);
    while (o_pready !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge i_ref_clk);
    end
    if (n == 20)
    begin
      n_errors++;
      end_of_test();
    end
    q = o_prdata;
    er = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    logic [31:0] q;
    logic        er;
    apb(1'b1, a, d, s, q, er);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic        er;
    apb(1'b0, a, 32'h0, 4'hf, q, er);
    `CHK(q, x)
  endtask
  task automatic ev(input aerusm_evt_t v);
    @(posedge i_ref_clk);
    i_err_evt <= v;
    @(posedge i_ref_clk);
    i_err_evt <= '0;
    #1;
    r = o_err_report;
    l = o_err_log;
  endtask
  task automatic rst_pulse(input logic por);
    @(posedge i_ref_clk);
    if (por) i_por_rst <= 1'b1;
    else i_rst <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    i_por_rst <= 1'b0;
    i_rst <= 1'b0;
  endtask
  // ***********************************
  // scenarios
  // ***********************************
  task automatic t_events();
    int pos[9] = '{20, 19, 18, 17, 16, 13, 12, 5, 4};
    for (int i = 0; i < 9; i++)
    begin
      ev(aerusm_evt_t'(9'h1 << i));
      `CHK(r, 32'h1 << pos[i])
      `CHK(l, 32'h1 << pos[i])
      rdchk(AERUSM_OFF_STAT, 32'h1 << pos[i]);
      wr(AERUSM_OFF_STAT, 32'h1 << pos[i]);
      rdchk(AERUSM_OFF_STAT, 32'h0);
    end
    wr(AERUSM_OFF_ISTAT, 32'h3);
    $display("test events done");
  endtask
  task automatic t_mask_irq();
    wr(AERUSM_OFF_MASK, 32'hffff_ffff);
    rdchk(AERUSM_OFF_MASK, 32'h001f_3031);
    wr(AERUSM_OFF_STAT, 32'hffff_ffff);
    rdchk(AERUSM_OFF_STAT, 32'h0);
    ev('1);
    `CHK(r, 32'h0)
    rdchk(AERUSM_OFF_STAT, 32'h001f_3030);
    wr(AERUSM_OFF_STAT, 32'hffff_ffff, 4'h1);
    rdchk(AERUSM_OFF_STAT, 32'h001f_3000);
    wr(AERUSM_OFF_STAT, 32'hffff_ffff);
    wr(AERUSM_OFF_MASK, 32'h0);
    wr(AERUSM_OFF_IMASK, 32'h1);
    rdchk(AERUSM_OFF_ISTAT, 32'h2);
    wr(AERUSM_OFF_ISTAT, 32'h3);
    ev(aerusm_evt_t'(9'h040));
    @(posedge i_ref_clk);
    #1;
    `CHK(o_irq, 1'b1)
    wr(AERUSM_OFF_ISTAT, 32'h1);
    @(posedge i_ref_clk);
    #1;
    `CHK(o_irq, 1'b0)
    wr(AERUSM_OFF_STAT, 32'h1000);
    $display("test mask and interrupt done");
  endtask
  task automatic t_sticky();
    ev(aerusm_evt_t'(9'h040));
    wr(AERUSM_OFF_MASK, 32'h10);
    rst_pulse(1'b0);
    rdchk(AERUSM_OFF_STAT, 32'h1000);
    rdchk(AERUSM_OFF_MASK, 32'h10);
    rdchk(AERUSM_OFF_IMASK, 32'h0);
    rst_pulse(1'b1);
    rdchk(AERUSM_OFF_STAT, 32'h0);
    rdchk(AERUSM_OFF_MASK, 32'h0);
    $display("test sticky done");
  endtask
  task automatic t_lock();
    wr(AERUSM_OFF_CAP, 32'hffff_ffff);
    rdchk(AERUSM_OFF_CAP, 32'hfff1_0001);
    i_next_capability_pointer_lock <= 1'b1;
    wr(AERUSM_OFF_CAP, 32'h0);
    rdchk(AERUSM_OFF_CAP, 32'hfff1_0001);
    i_next_capability_pointer_lock <= 1'b0;
    apb(1'b0, 12'h10c, 32'h0, 4'hf, r, e);
    `CHK({e, r}, 33'h1_0000_0000)
    i_surprise_down_report_capable <= 1'b0;
    ev(aerusm_evt_t'(9'h080));
    `CHK(r, 32'h0)
    rdchk(AERUSM_OFF_STAT, 32'h0);
    $display("test lock and capability done");
  endtask
  task automatic end_of_test();
    $display("checks=%0d errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ***********************************
  // main sequence and watchdog
  // ***********************************
  initial
  begin
    {i_rst, i_por_rst, i_psel, i_penable, i_pwrite, i_next_capability_pointer_lock} = 6'h30;
    {i_paddr, i_pwdata, i_pstrb} = '0;
    i_err_evt = '0;
    i_surprise_down_report_capable = 1'b1;
    repeat (6) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    i_por_rst <= 1'b0;
    rdchk(AERUSM_OFF_CAP, 32'h1801_0001);
    rdchk(AERUSM_OFF_STAT, 32'h0);
    rdchk(AERUSM_OFF_MASK, 32'h0);
    t_events();
    t_mask_irq();
    t_sticky();
    t_lock();
    end_of_test();
  end
  initial
  begin
    #400000;
    n_errors++;
    end_of_test();
  end
endmodule
